// File: sep_cmd_protect.sv
// Function
// - writes need whole bytes of serial clocks
// - data changes need prior set-latch command
// - select must rise right after last bit
// - last bit is opcode or data byte end
// - block-protect pair selects protected range
// - unknown opcode deselects until next select
// - one opcode byte starts each command
// - id variants choose by address bit ten
// - only address bits 13..0 matter
// - set-latch command alone sets the latch
// - latch changes apply at deselect
// - latch clears on reset, clear, completion
// - status read works always, repeats until the 12-bit count wraps
// - busy bit high during write cycles
// - latch low refuses all writes
// - protect bits change only by status write
// - protected range refuses array writes
// - disable bit plus low pin locks status
// - reset clears latch, busy; keeps nonvolatile
// - msb first, sample rise, drive fall
// - status bits 6..4 read zero
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"
module sep_cmd_protect import sep_pkg::*; #(
	parameter int TW_CYCLES = `SEP_TW_NS / `SEP_CLK_NS,
	parameter int CNT_W = 12,
	parameter bit ID_PAGE_EN = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic wp_n,
	input wire logic [1:0] nv_bp,
	input wire logic nv_status_write_disable,
	input wire logic nv_id_lock,
	output logic dout,
	output logic dout_oe,
	output logic [7:0] status_register,
	output logic hw_lock_mode,
	output logic arr_wr_start,
	output logic id_wr_start,
	output logic id_lock_start,
	output logic [`SEP_ADDR_MSB:0] wr_addr,
	output logic nv_wr_stb,
	output logic [1:0] nv_wr_bp,
	output logic nv_wr_status_write_disable
);
	// ==========================================================
	// decoding helpers
	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == `SEP_OP_SET_WL) || (op == `SEP_OP_CLR_WL) ||
			(op == `SEP_OP_STAT_RD) || (op == `SEP_OP_STAT_WR) ||
			(op == `SEP_OP_ARR_RD) || (op == `SEP_OP_ARR_WR) ||
			(ID_PAGE_EN && ((op == `SEP_OP_ID_RD) ||
			(op == `SEP_OP_ID_WR)));
	endfunction

	function automatic logic arr_protected(input logic [1:0] bp,
		input logic [`SEP_ADDR_MSB:0] a);
		unique case (bp)
			2'h0: arr_protected = 1'b0;
			2'h1: arr_protected = (a >= `SEP_QUARTER_BASE);
			2'h2: arr_protected = (a >= `SEP_HALF_BASE);
			2'h3: arr_protected = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// link domain: shifting on the serial clock
	logic frame_end_l;
	logic fresh;
	logic [CNT_W-1:0] lk_cnt;
	logic [7:0] lk_sh;
	logic [7:0] lk_op;
	logic [15:0] lk_addr;
	logic lk_long;
	logic lk_op_done;
	logic lk_tog;
	logic [CNT_W-1:0] cur_cnt;
	logic [7:0] cur_byte;
	logic [7:0] st_q1;
	logic [7:0] st_q2;
	logic [2:0] out_idx;

	assign frame_end_l = cs_n | ~rst_n;
	assign cur_cnt = fresh ? CNT_W'(1) : CNT_W'(lk_cnt + CNT_W'(1));
	assign cur_byte = {lk_sh[6:0], din};

	// fresh is set while deselected, so the first edge of a frame restarts
	// counting without wiping what the last frame left for the other side
	always_ff @(posedge sclk or posedge frame_end_l) begin
		if (frame_end_l) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lk_cnt <= '0;
			lk_sh <= 8'h00;
			lk_op <= 8'h00;
			lk_addr <= 16'h0000;
			lk_long <= 1'b0;
			lk_op_done <= 1'b0;
			lk_tog <= 1'b0;
		end else begin
			lk_cnt <= cur_cnt;
			lk_sh <= cur_byte;
			if (fresh) begin
				lk_tog <= ~lk_tog;
				lk_long <= 1'b0;
				lk_op_done <= 1'b0;
			end
			if (cur_cnt == CNT_W'(`SEP_OP_BITS)) begin
				lk_op <= cur_byte;
				lk_op_done <= 1'b1;
			end
			// byte one doubles as the data byte of a status write
			if (cur_cnt == CNT_W'(`SEP_SR_BITS)) begin
				lk_addr[15:8] <= cur_byte;
			end
			if (cur_cnt == CNT_W'(`SEP_SR_BITS + `SEP_OP_BITS)) begin
				lk_addr[7:0] <= cur_byte;
			end
			if (cur_cnt == CNT_W'(`SEP_WR_MIN_BITS)) begin
				lk_long <= 1'b1;
			end
		end
	end

	// status copy for the shifter; each bit is an independent level,
	// so a per-bit two-stage sync is enough for polling
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q1 <= 8'h00;
			st_q2 <= 8'h00;
		end else begin
			st_q1 <= status_register;
			st_q2 <= st_q1;
		end
	end

	// unknown opcodes never match, so the output stays off to frame end
	always_ff @(negedge sclk or posedge frame_end_l) begin
		if (frame_end_l) begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
			out_idx <= 3'h7;
		end else if (!fresh && lk_op_done &&
			lk_op == `SEP_OP_STAT_RD) begin
			dout <= st_q2[out_idx];
			dout_oe <= 1'b1;
			out_idx <= 3'(out_idx - 3'h1);
		end
	end

	// ==========================================================
	// system domain: synchronisers
	logic cs_q1, cs_q2, cs_q3;
	logic wp_q1, wp_q2;
	logic tog_q1, tog_q2, tog_q3;
	logic frame_new;
	logic frame_rise;
	logic frame_ok;
	logic tog_edge;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q1 <= 1'b1;
			cs_q2 <= 1'b1;
			cs_q3 <= 1'b1;
			wp_q1 <= 1'b1;
			wp_q2 <= 1'b1;
			tog_q1 <= 1'b0;
			tog_q2 <= 1'b0;
			tog_q3 <= 1'b0;
		end else begin
			cs_q1 <= cs_n;
			cs_q2 <= cs_q1;
			cs_q3 <= cs_q2;
			wp_q1 <= wp_n;
			wp_q2 <= wp_q1;
			tog_q1 <= lk_tog;
			tog_q2 <= tog_q1;
			tog_q3 <= tog_q2;
		end
	end

	assign tog_edge = tog_q2 ^ tog_q3;
	assign frame_rise = cs_q2 & ~cs_q3;
	assign frame_ok = frame_new | tog_edge;

	// a frame with no clocks leaves stale counts; only frames that
	// toggled are judged. a new toggle wins over the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_new <= 1'b0;
		end else begin
			frame_new <= tog_edge | (frame_new & ~frame_rise);
		end
	end

	// ==========================================================
	// frame judgement; link values are still since the clock stops
	// once select is high
	sep_state_t state;
	sep_job_t job;
	logic write_enable_latch, write_in_progress, status_write_disable, id_locked;
	logic [1:0] bp;
	logic [7:0] new_sr;
	logic [31:0] tw_cnt;
	logic [`SEP_ADDR_MSB:0] lk_a;
	logic judge;
	logic whole_bytes;
	logic is_set, is_clr, is_sr_wr, is_arr_wr, is_id_wr;

	assign hw_lock_mode = status_write_disable & ~wp_q2;
	assign lk_a = lk_addr[`SEP_ADDR_MSB:0];
	// one judgement per frame, on the synced select edge; a frame that
	// ends while a write cycle runs is dropped, since the array and the
	// store are busy and a second job would have nowhere to go
	assign judge = frame_rise & frame_ok & (state == sep_st_idle) & op_known(lk_op);
	assign whole_bytes = (lk_cnt[2:0] == 3'h0);
	assign is_set = judge && lk_op == `SEP_OP_SET_WL &&
		lk_cnt == CNT_W'(`SEP_OP_BITS) && !lk_long;
	assign is_clr = judge && lk_op == `SEP_OP_CLR_WL &&
		lk_cnt == CNT_W'(`SEP_OP_BITS) && !lk_long;
	assign is_sr_wr = judge && lk_op == `SEP_OP_STAT_WR &&
		lk_cnt == CNT_W'(`SEP_SR_BITS) && !lk_long &&
		write_enable_latch && !hw_lock_mode;
	// refused writes keep the latch, so the master may retry at once
	// without another set-latch frame
	assign is_arr_wr = judge && lk_op == `SEP_OP_ARR_WR && lk_long &&
		whole_bytes && write_enable_latch && !arr_protected(bp, lk_a);
	assign is_id_wr = judge && lk_op == `SEP_OP_ID_WR && lk_long &&
		whole_bytes && write_enable_latch && !id_locked && bp != 2'h3;

	// ==========================================================
	// status and write cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= sep_st_load;
			job <= sep_job_array;
			write_enable_latch <= `SEP_WEL_RST;
			write_in_progress <= `SEP_WIP_RST;
			bp <= `SEP_BP_RST;
			status_write_disable <= `SEP_STATUS_WRITE_DISABLE_RST;
			id_locked <= 1'b0;
			new_sr <= 8'h00;
			tw_cnt <= '0;
			wr_addr <= '0;
		end else begin
			unique case (state)
				sep_st_load: begin
					bp <= nv_bp;
					status_write_disable <= nv_status_write_disable;
					id_locked <= nv_id_lock;
					state <= sep_st_idle;
				end
				sep_st_idle: begin
					// reloaded every idle cycle so each spell has full length
					tw_cnt <= 32'(TW_CYCLES - 1);
					if (is_set) begin
						write_enable_latch <= 1'b1;
					end
					if (is_clr) begin
						write_enable_latch <= 1'b0;
					end
					if (is_sr_wr) begin
						new_sr <= lk_addr[15:8];
						job <= sep_job_status;
						write_in_progress <= 1'b1;
						state <= sep_st_busy;
					end
					if (is_arr_wr) begin
						wr_addr <= lk_a;
						job <= sep_job_array;
						write_in_progress <= 1'b1;
						state <= sep_st_busy;
					end
					if (is_id_wr) begin
						wr_addr <= lk_a;
						job <= lk_addr[`SEP_ID_SEL_BIT] ? sep_job_id_lock :
							sep_job_id_page;
						write_in_progress <= 1'b1;
						state <= sep_st_busy;
					end
				end
				sep_st_busy: begin
					tw_cnt <= 32'(tw_cnt - 32'h1);
					if (tw_cnt == 32'h0) begin
						write_in_progress <= 1'b0;
						write_enable_latch <= 1'b0;
						if (job == sep_job_status) begin
							bp <= {new_sr[`SEP_ST_BP_HI],
								new_sr[`SEP_ST_BP_LO]};
							status_write_disable <= new_sr[`SEP_ST_STATUS_WRITE_DISABLE];
						end
						if (job == sep_job_id_lock) begin
							id_locked <= 1'b1;
						end
						state <= sep_st_idle;
					end
				end
			endcase
		end
	end

	// strobes toward the array and the nonvolatile store; the store
	// itself lives outside, these only report what must be kept
	// nv_wr_* follow new_sr freely and mean something only with the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arr_wr_start <= 1'b0;
			id_wr_start <= 1'b0;
			id_lock_start <= 1'b0;
			nv_wr_stb <= 1'b0;
			nv_wr_bp <= `SEP_BP_RST;
			nv_wr_status_write_disable <= `SEP_STATUS_WRITE_DISABLE_RST;
		end else begin
			arr_wr_start <= is_arr_wr;
			id_wr_start <= is_id_wr && !lk_addr[`SEP_ID_SEL_BIT];
			id_lock_start <= is_id_wr && lk_addr[`SEP_ID_SEL_BIT];
			nv_wr_stb <= (state == sep_st_busy) && (tw_cnt == 32'h0) &&
				(job == sep_job_status);
			nv_wr_bp <= {new_sr[`SEP_ST_BP_HI], new_sr[`SEP_ST_BP_LO]};
			nv_wr_status_write_disable <= new_sr[`SEP_ST_STATUS_WRITE_DISABLE];
		end
	end

	// fixed zero at bits 6..4; status write never touches bits 1..0
	assign status_register = {status_write_disable, 3'h0, bp, write_enable_latch, write_in_progress};

endmodule // sep_cmd_protect
`default_nettype wire

// File: sep_cmd_protect_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"
module sep_cmd_protect_assertions #(
	parameter int TW_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] status_register,
	input wire logic hw_lock_mode,
	input wire logic arr_wr_start,
	input wire logic id_wr_start,
	input wire logic id_lock_start,
	input wire logic [`SEP_ADDR_MSB:0] wr_addr,
	input wire logic nv_wr_stb
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// helpers
	logic [15:0] busy_len;
	wire [1:0] bp = status_register[3:2];
	wire in_quarter = bp == 2'h1 && wr_addr[13:12] == 2'h3;
	wire prot = bp == 2'h3 || (bp == 2'h2 && wr_addr[13]) || in_quarter;
	// counts cycles of one busy spell so its length is checkable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) busy_len <= 16'h0;
		else if (!status_register[0]) busy_len <= 16'h0;
		else busy_len <= busy_len + 16'h1;
	end
	// ==========================================================
	// checks
	a_wip_follows: assert property (arr_wr_start |-> ##[0:2] status_register[0]) else $error("busy bit did not rise");
	a_start_needs_wel: assert property (arr_wr_start |-> status_register[1]) else $error("write taken without latch");
	a_busy_length: assert property ($fell(status_register[0]) |-> busy_len >= TW_CYCLES && busy_len <= TW_CYCLES + 2) else $error("busy spell length");
	a_wel_ends: assert property ($fell(status_register[0]) |-> ##[0:2] !status_register[1]) else $error("latch kept after cycle");
	a_range_guard: assert property (arr_wr_start |-> !prot) else $error("protected address written");
	a_id_guard: assert property ((id_wr_start || id_lock_start) |-> bp != 2'h3) else $error("id page written under full guard");
	a_zero_bits: assert property (status_register[6:4] == 3'h0) else $error("unused bits not zero");
	a_lock_mode: assert property (hw_lock_mode |-> status_register[7]) else $error("lock without disable bit");
	a_lock_keeps: assert property (hw_lock_mode && $past(hw_lock_mode) |-> $stable({status_register[7], bp})) else $error("guard bits moved in lock");
	a_lock_nowr: assert property (hw_lock_mode |-> !nv_wr_stb) else $error("status stored in lock");
	c_arr: cover property (arr_wr_start);
	c_nv: cover property (nv_wr_stb);
	c_lock: cover property (id_lock_start);
endmodule // sep_cmd_protect_assertions
`default_nettype wire

// File: sep_cmd_protect_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"
module sep_cmd_protect_tb_top;
	logic clk = 1'b0;
	logic rst_n, wp_n, sclk, cs_n, din, dout, dout_oe, nv_status_write_disable, nv_id_lock;
	logic hw_lock_mode, arr_wr_start, id_wr_start, id_lock_start, nv_wr_stb;
	logic nv_wr_status_write_disable;
	logic [1:0] nv_bp, nv_wr_bp;
	logic [7:0] status_register, rd;
	logic [13:0] wr_addr;
	logic [13:0] n_arr = '0;
	logic [13:0] n_id = '0;
	logic [13:0] n_lock = '0;
	logic [13:0] n_nv = '0;
	logic [13:0] last_nv = '0;
	int mismatches, samples_checked;
	wire miso = dout_oe ? dout : ~dout;
	// busy spell must outlast one status read frame (about 40 clk)
	sep_cmd_protect #(.TW_CYCLES(200)) dut (.clk(clk), .rst_n(rst_n),
		.sclk(sclk), .cs_n(cs_n), .din(din), .wp_n(wp_n), .nv_bp(nv_bp),
		.nv_status_write_disable(nv_status_write_disable), .nv_id_lock(nv_id_lock), .dout(dout),
		.dout_oe(dout_oe), .status_register(status_register),
		.hw_lock_mode(hw_lock_mode), .arr_wr_start(arr_wr_start),
		.id_wr_start(id_wr_start), .id_lock_start(id_lock_start),
		.wr_addr(wr_addr), .nv_wr_stb(nv_wr_stb), .nv_wr_bp(nv_wr_bp),
		.nv_wr_status_write_disable(nv_wr_status_write_disable));
	sep_spi_master m (.sclk(sclk), .cs_n(cs_n), .din(din), .miso(miso));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		n_arr <= n_arr + 14'(arr_wr_start);
		n_id <= n_id + 14'(id_wr_start);
		n_lock <= n_lock + 14'(id_lock_start);
		n_nv <= n_nv + 14'(nv_wr_stb);
		if (nv_wr_stb) last_nv <= {11'h0, nv_wr_status_write_disable, nv_wr_bp};
	end
	// ==========================================================
	// tasks
	task results;
		if (mismatches == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [13:0] got, input logic [13:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task st(input logic [7:0] e);
		chk(14'(status_register), 14'(e));
	endtask
	// judgement lands a few clk after the select rises
	task frame(input logic [39:0] d, input int n);
		m.xfer(d, n, rd);
		repeat (8) @(posedge clk);
	endtask
	task rd_status(input logic [7:0] e);
		frame({8'h05, 8'h00}, 16);
		chk(14'(rd), 14'(e));
		st(e);
	endtask
	task wel_on;
		frame(8'h06, 8);
	endtask
	// poll busy before the next command
	task idle;
		for (int i = 0; i < 1000 && status_register[0] !== 1'b0; i++) @(posedge clk);
		// let the end-of-cycle strobe reach the counters
		repeat (2) @(posedge clk);
	endtask
	// ==========================================================
	// tests
	initial begin
		{rst_n, nv_bp, nv_status_write_disable, nv_id_lock} = '0;
		wp_n = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		st(8'h00);
		frame({8'h02, 16'h0100, 8'h5a}, 32);
		chk(n_arr, 14'h0);
		frame({8'h06, 1'b0}, 9);
		st(8'h00);
		frame({8'h4c, 8'h06}, 16);
		st(8'h00);
		wel_on;
		rd_status(8'h02);
		frame({8'h05, 16'h0}, 24);
		chk(14'(rd), 14'h2);
		frame({8'h02, 16'h3000, 8'h5a, 7'h0}, 39);
		chk(n_arr, 14'h0);
		frame({8'h02, 16'hf000, 8'h5a}, 32);
		chk(n_arr, 14'h1);
		chk(wr_addr, 14'h3000);
		rd_status(8'h03);
		idle;
		rd_status(8'h00);
		wel_on;
		frame({8'h01, 8'hfc}, 16);
		idle;
		chk(last_nv, 14'h7);
		rd_status(8'h8c);
		wel_on;
		frame({8'h02, 16'h0000, 8'h11}, 32);
		frame({8'h82, 16'h0000, 8'h11}, 32);
		chk(n_arr + n_id, 14'h1);
		#1 wp_n = 1'b0;
		repeat (4) @(posedge clk);
		chk(14'(hw_lock_mode), 14'h1);
		frame({8'h01, 8'h00}, 16);
		chk(n_nv, 14'h1);
		rd_status(8'h8e);
		#1 wp_n = 1'b1;
		frame({8'h01, 8'h04}, 16);
		idle;
		rd_status(8'h04);
		wel_on;
		frame({8'h02, 16'h2fff, 8'h11}, 32);
		idle;
		wel_on;
		frame({8'h02, 16'h3000, 8'h11}, 32);
		chk(n_arr, 14'h2);
		frame({8'h82, 16'h0000, 8'h11}, 32);
		idle;
		wel_on;
		frame({8'h82, 16'h0400, 8'h11}, 32);
		idle;
		chk({n_id[6:0], n_lock[6:0]}, 14'h81);
		wel_on;
		frame(8'h04, 8);
		rd_status(8'h04);
		#1 nv_bp = 2'h2;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		st(8'h08);
		results;
	end
	initial begin
		#2000000;
		mismatches++;
		results;
	end
endmodule // sep_cmd_protect_tb_top
bind sep_cmd_protect sep_cmd_protect_assertions #(.TW_CYCLES(TW_CYCLES)) u_chk (
	.clk(clk), .rst_n(rst_n), .status_register(status_register),
	.hw_lock_mode(hw_lock_mode), .arr_wr_start(arr_wr_start),
	.id_wr_start(id_wr_start), .id_lock_start(id_lock_start),
	.wr_addr(wr_addr), .nv_wr_stb(nv_wr_stb));
`default_nettype wire

// File: sep_pkg.sv
package sep_pkg;
	// ==========================================================
	// controller states
	typedef enum logic [1:0] {
		sep_st_load,
		sep_st_idle,
		sep_st_busy
	} sep_state_t;
	// ==========================================================
	// kind of self-timed cycle running
	typedef enum logic [1:0] {
		sep_job_array,
		sep_job_status,
		sep_job_id_page,
		sep_job_id_lock
	} sep_job_t;
endpackage

// File: sep_regs.svh
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH
// ==========================================================
// opcodes
`define SEP_OP_SET_WL 8'h06
`define SEP_OP_CLR_WL 8'h04
`define SEP_OP_STAT_RD 8'h05
`define SEP_OP_STAT_WR 8'h01
`define SEP_OP_ARR_RD 8'h03
`define SEP_OP_ARR_WR 8'h02
`define SEP_OP_ID_RD 8'h83
`define SEP_OP_ID_WR 8'h82
// ==========================================================
// status byte fields
`define SEP_ST_WIP 0
`define SEP_ST_WEL 1
`define SEP_ST_BP_LO 2
`define SEP_ST_BP_HI 3
`define SEP_ST_STATUS_WRITE_DISABLE 7
`define SEP_WEL_RST 1'b0
`define SEP_WIP_RST 1'b0
`define SEP_BP_RST 2'h0
`define SEP_STATUS_WRITE_DISABLE_RST 1'b0
// ==========================================================
// addressing and protection
`define SEP_ADDR_MSB 13
`define SEP_ID_SEL_BIT 10
`define SEP_QUARTER_BASE 14'h3000
`define SEP_HALF_BASE 14'h2000
// ==========================================================
// frame lengths in serial clocks and timing
`define SEP_OP_BITS 8
`define SEP_SR_BITS 16
`define SEP_WR_MIN_BITS 32
`define SEP_CLK_NS 40
`define SEP_TW_NS 5000000
`endif

// File: sep_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sep_spi_master (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// mode 0: clock parks low and runs only inside a frame
	task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
		rd = 8'h00;
		#13 cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			din = d[i];
			#40 sclk = 1'b1;
			rd = {rd[6:0], miso};
			#40 sclk = 1'b0;
		end
		#20 cs_n = 1'b1;
		// released line must not keep its last value
		din = ~din;
		#80;
	endtask
endmodule // sep_spi_master
`default_nettype wire
